//--- common/ctm_core_regs.svh
`ifndef CTM_CORE_REGS_SVH
`define CTM_CORE_REGS_SVH

`define CTM_CLK_PERIOD_NS 10
`define CTM_NUM_CH 13
`define CTM_PROX_CH 4'hC
`define CTM_MAX_ELE 4'hC
`define CTM_FIRST_ELE 4'h0
// Charge time code n gives 0.5 us << (n-1): 0.5 us .. 32 us
`define CTM_TCHG_MIN_NS 500
`define CTM_TCHG_UNIT_CYC ((`CTM_TCHG_MIN_NS + `CTM_CLK_PERIOD_NS - 1) / `CTM_CLK_PERIOD_NS)
`define CTM_TCODE_MIN 3'h1
// Charge current code is in uA, 1..63
`define CTM_CUR_MIN 6'h01
`define CTM_CUR_SEED 6'h20
`define CTM_ACFG_TOP_BIT 3'h5
`define CTM_DISCH_NS 1000
`define CTM_DISCH_CYC (`CTM_DISCH_NS / `CTM_CLK_PERIOD_NS)
// Base sample period, shifted left by the interval code (1 ms .. 128 ms)
`define CTM_PERIOD_NS 1000000
`define CTM_PERIOD_CYC (`CTM_PERIOD_NS / `CTM_CLK_PERIOD_NS)
// Electrode config register fields
`define CTM_ELCFG_RUN_MSB 5
`define CTM_ELCFG_PROX_MSB 5
`define CTM_ELCFG_PROX_LSB 4
`define CTM_ELCFG_ELE_MSB 3

`endif

//--- common/ctm_pkg.sv
package ctm_pkg;
   typedef logic [9:0] ctm_sample_t;
   typedef logic [7:0] ctm_base8_t;
   typedef logic [7:0] ctm_thr_t;
   typedef enum logic [2:0] {
      S_STOP      = 3'b000,
      S_START     = 3'b001,
      S_CHARGE    = 3'b010,
      S_CONVERT   = 3'b011,
      S_DISCHARGE = 3'b100,
      S_FILTER    = 3'b101,
      S_WAIT      = 3'b110
   } ctm_state_t;
endpackage : ctm_pkg

//--- rtl/ctm_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctm_core_regs.svh"

module ctm_core #(
   parameter int unsigned P_PERIOD_CYCLES = `CTM_PERIOD_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_electrode_config_reg,
   input wire logic [5:0] i_charge_current,
   input wire logic [2:0] i_charge_time,
   input wire logic [1:0] i_first_stage_sample_count,
   input wire logic [1:0] i_second_stage_sample_count,
   input wire logic [2:0] i_second_stage_sample_interval,
   input wire logic [2:0] i_base_shift_ele,
   input wire logic [2:0] i_base_shift_prox,
   input wire ctm_pkg::ctm_thr_t [12:0] i_touch_thr,
   input wire ctm_pkg::ctm_thr_t [12:0] i_release_thr,
   input wire logic [2:0] i_debounce_touch,
   input wire logic [2:0] i_debounce_release,
   input wire logic i_autocfg_start,
   input wire ctm_pkg::ctm_sample_t i_autocfg_target,
   input wire logic i_irq_ack,
   input wire logic i_adc_done,
   input wire ctm_pkg::ctm_sample_t i_adc_data,
   output logic [3:0] o_mux_sel,
   output logic [12:0] o_short_gnd,
   output logic o_charge_en,
   output logic [5:0] o_charge_current,
   output logic o_adc_start,
   output logic o_discharge,
   output logic o_autocfg_busy,
   output ctm_pkg::ctm_sample_t [12:0] o_filtered_data,
   output ctm_pkg::ctm_base8_t [12:0] o_baseline,
   output logic [12:0] o_touch_status,
   output logic o_irq_n
);
   import ctm_pkg::*;
   function automatic logic [12:0] ctm_onehot(input logic [3:0] ch);
      ctm_onehot = 13'h0001 << ch;
   endfunction : ctm_onehot
   ctm_state_t state_ff, nxt_state;
   logic [3:0] ch_ff, nxt_ch, mux_ff;
   logic [2:0] smp_ff, nxt_smp, acfg_bit_ff;
   logic [12:0] acc_ff, nxt_acc, init_ff, status_ff, short_ff;
   logic [31:0] timer_ff, nxt_timer;
   ctm_sample_t filt_ff [13];
   logic [9:0] base_ff [13];
   logic [2:0] deb_ff [13];
   logic [5:0] cur_ff [13];
   logic acfg_req_ff, acfg_act_ff, acfg_used_ff, irq_n_ff;
   logic chg_ff, adc_ff, dis_ff;
   logic [5:0] cur_out_ff;
   // Sequencing controls
   wire run = |i_electrode_config_reg[`CTM_ELCFG_RUN_MSB:0];
   wire prox_en = |i_electrode_config_reg[`CTM_ELCFG_PROX_MSB:`CTM_ELCFG_PROX_LSB];
   wire [3:0] ele_raw = i_electrode_config_reg[`CTM_ELCFG_ELE_MSB:0];
   wire [3:0] nele = (ele_raw > `CTM_MAX_ELE) ? `CTM_MAX_ELE : ele_raw;
   wire [3:0] first_ch = prox_en ? `CTM_PROX_CH : `CTM_FIRST_ELE;
   wire is_prox = (ch_ff == `CTM_PROX_CH);
   wire is_last = is_prox ? (nele == 4'h0) : ((ch_ff + 4'h1) >= nele);
   wire [3:0] next_ch = is_prox ? `CTM_FIRST_ELE : ch_ff + 4'h1;
   wire [2:0] tcode = (i_charge_time < `CTM_TCODE_MIN) ? `CTM_TCODE_MIN : i_charge_time;
   wire [31:0] tchg_cyc = 32'(`CTM_TCHG_UNIT_CYC) << (tcode - `CTM_TCODE_MIN);
   wire [31:0] wait_cyc = P_PERIOD_CYCLES << i_second_stage_sample_interval;
   wire [2:0] smp_max = 3'((4'h1 << i_first_stage_sample_count) - 4'h1);
   wire smp_last = (smp_ff == smp_max);

   always_comb begin
      nxt_state = state_ff;
      nxt_ch = ch_ff;
      nxt_smp = smp_ff;
      nxt_acc = acc_ff;
      nxt_timer = (timer_ff == 32'h0) ? 32'h0 : timer_ff - 32'h1;
      case (state_ff)
         S_STOP: begin
            if (run) begin
               nxt_state = S_START;
            end
         end
         S_START: begin
            nxt_ch = first_ch;
            nxt_smp = 3'h0;
            nxt_acc = 13'h0000;
            nxt_timer = tchg_cyc - 32'h1;
            nxt_state = S_CHARGE;
         end
         S_CHARGE: begin
            if (timer_ff == 32'h0) begin
               nxt_state = S_CONVERT;
            end
         end
         S_CONVERT: begin
            if (i_adc_done) begin
               nxt_acc = acc_ff + {3'h0, i_adc_data};
               nxt_timer = 32'(`CTM_DISCH_CYC) - 32'h1;
               nxt_state = S_DISCHARGE;
            end
         end
         S_DISCHARGE: begin
            if (timer_ff == 32'h0) begin
               if (smp_last) begin
                  nxt_state = S_FILTER;
               end else begin
                  nxt_smp = smp_ff + 3'h1;
                  nxt_timer = tchg_cyc - 32'h1;
                  nxt_state = S_CHARGE;
               end
            end
         end
         S_FILTER: begin
            nxt_acc = 13'h0000;
            nxt_smp = 3'h0;
            if (is_last) begin
               nxt_timer = wait_cyc - 32'h1;
               nxt_state = S_WAIT;
            end else begin
               nxt_ch = next_ch;
               nxt_timer = tchg_cyc - 32'h1;
               nxt_state = S_CHARGE;
            end
         end
         S_WAIT: begin
            if (timer_ff == 32'h0) begin
               nxt_state = S_START;
            end
         end
         default: begin
            nxt_state = S_STOP;
         end
      endcase
      if (!run) begin
         nxt_state = S_STOP;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         state_ff <= S_STOP;
         ch_ff <= 4'h0;
         smp_ff <= 3'h0;
         acc_ff <= 13'h0000;
         timer_ff <= 32'h0;
      end else begin
         state_ff <= nxt_state;
         ch_ff <= nxt_ch;
         smp_ff <= nxt_smp;
         acc_ff <= nxt_acc;
         timer_ff <= nxt_timer;
      end
   end

   // Front-end drive, registered from next state
   wire meas_nxt = (nxt_state == S_CHARGE) || (nxt_state == S_CONVERT);
   wire [12:0] nxt_short = !meas_nxt ? 13'h1FFF :
                           (nxt_ch == `CTM_PROX_CH) ? 13'h0000 : ~ctm_onehot(nxt_ch);
   wire [5:0] cur_pick = acfg_used_ff ? cur_ff[nxt_ch] : i_charge_current;
   wire [5:0] cur_drive = (cur_pick < `CTM_CUR_MIN) ? `CTM_CUR_MIN : cur_pick;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         mux_ff <= 4'h0;
         short_ff <= 13'h1FFF;
         chg_ff <= 1'b0;
         adc_ff <= 1'b0;
         dis_ff <= 1'b0;
         cur_out_ff <= `CTM_CUR_MIN;
      end else begin
         mux_ff <= nxt_ch;
         short_ff <= nxt_short;
         chg_ff <= (nxt_state == S_CHARGE);
         adc_ff <= (state_ff == S_CHARGE) && (nxt_state == S_CONVERT);
         dis_ff <= (nxt_state == S_DISCHARGE);
         cur_out_ff <= cur_drive;
      end
   end
   // Filter path for the channel just measured
   wire [9:0] s1 = 10'(acc_ff >> i_first_stage_sample_count);
   wire [9:0] filt_old = filt_ff[ch_ff];
   wire [9:0] base_old = base_ff[ch_ff];
   wire signed [10:0] d2 = $signed({1'b0, s1}) - $signed({1'b0, filt_old});
   wire [9:0] filt_new = init_ff[ch_ff] ? s1 :
                         filt_old + 10'(d2 >>> i_second_stage_sample_count);
   wire [2:0] bshift = is_prox ? i_base_shift_prox : i_base_shift_ele;
   wire signed [10:0] d3 = $signed({1'b0, filt_new}) - $signed({1'b0, base_old});
   wire [9:0] base_new = init_ff[ch_ff] ? filt_new : base_old + 10'(d3 >>> bshift);
   // Count drops as capacitance rises, so a touch pulls data below baseline
   wire [10:0] touch_lvl = {1'b0, filt_new} + {3'h0, i_touch_thr[ch_ff]};
   wire [10:0] rel_lvl = {1'b0, filt_new} + {3'h0, i_release_thr[ch_ff]};
   wire touch_cand = ({1'b0, base_new} > touch_lvl);
   wire rel_cand = ({1'b0, base_new} < rel_lvl);
   wire cur_stat = status_ff[ch_ff];
   wire want_flip = cur_stat ? rel_cand : touch_cand;
   wire [2:0] deb_need = cur_stat ? i_debounce_release : i_debounce_touch;
   wire [3:0] deb_inc = {1'b0, deb_ff[ch_ff]} + 4'h1;
   wire flip = want_flip && (deb_inc > {1'b0, deb_need});
   wire [2:0] deb_new = (want_flip && !flip) ? deb_inc[2:0] : 3'h0;
   wire do_filt = (state_ff == S_FILTER);
   // Successive approximation on current, one bit per scan cycle
   wire [5:0] bit_mask = 6'h01 << acfg_bit_ff;
   wire [5:0] low_mask = (acfg_bit_ff == 3'h0) ? 6'h00 : 6'h01 << (acfg_bit_ff - 3'h1);
   wire [5:0] cur_trim = (s1 > i_autocfg_target) ? (cur_ff[ch_ff] & ~bit_mask) : cur_ff[ch_ff];
   wire [5:0] cur_new = cur_trim | low_mask;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         for (int i = 0; i < `CTM_NUM_CH; i++) begin
            filt_ff[i] <= 10'h000;
            base_ff[i] <= 10'h000;
            deb_ff[i] <= 3'h0;
         end
         init_ff <= 13'h1FFF;
         status_ff <= 13'h0000;
      end else if (do_filt) begin
         filt_ff[ch_ff] <= filt_new;
         base_ff[ch_ff] <= base_new;
         deb_ff[ch_ff] <= deb_new;
         init_ff[ch_ff] <= 1'b0;
         status_ff[ch_ff] <= cur_stat ^ flip;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         for (int i = 0; i < `CTM_NUM_CH; i++) begin
            cur_ff[i] <= `CTM_CUR_SEED;
         end
         acfg_req_ff <= 1'b0;
         acfg_act_ff <= 1'b0;
         acfg_used_ff <= 1'b0;
         acfg_bit_ff <= `CTM_ACFG_TOP_BIT;
      end else if (i_autocfg_start && !acfg_act_ff) begin
         for (int i = 0; i < `CTM_NUM_CH; i++) begin
            cur_ff[i] <= `CTM_CUR_SEED;
         end
         acfg_req_ff <= 1'b1;
         acfg_used_ff <= 1'b1;
         acfg_bit_ff <= `CTM_ACFG_TOP_BIT;
      end else if (acfg_req_ff && state_ff == S_START) begin
         acfg_req_ff <= 1'b0;
         acfg_act_ff <= 1'b1;
      end else if (acfg_act_ff && do_filt) begin
         cur_ff[ch_ff] <= cur_new;
         if (is_last) begin
            acfg_act_ff <= (acfg_bit_ff != 3'h0);
            acfg_bit_ff <= (acfg_bit_ff == 3'h0) ? 3'h0 : acfg_bit_ff - 3'h1;
         end
      end
   end

   // Interrupt held low until acknowledged; a new event wins over the ack
   wire flip_evt = do_filt && flip;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         irq_n_ff <= 1'b1;
      end else begin
         irq_n_ff <= !(flip_evt || (!irq_n_ff && !i_irq_ack));
      end
   end

   generate
      for (genvar g = 0; g < `CTM_NUM_CH; g++) begin : g_out
         assign o_filtered_data[g] = filt_ff[g];
         assign o_baseline[g] = base_ff[g][9:2];
      end
   endgenerate

   assign o_mux_sel = mux_ff;
   assign o_short_gnd = short_ff;
   assign o_charge_en = chg_ff;
   assign o_charge_current = cur_out_ff;
   assign o_adc_start = adc_ff;
   assign o_discharge = dis_ff;
   assign o_autocfg_busy = acfg_act_ff;
   assign o_touch_status = status_ff;
   assign o_irq_n = irq_n_ff;

   // Checking helpers
   logic [31:0] chg_len_ff, chg_exp_ff;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         chg_len_ff <= 32'h0;
         chg_exp_ff <= 32'h0;
      end else begin
         chg_len_ff <= o_charge_en ? chg_len_ff + 32'h1 : 32'h0;
         if (state_ff != S_CHARGE && nxt_state == S_CHARGE) begin
            chg_exp_ff <= tchg_cyc;
         end
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   sequence s_cycle_start;
      state_ff == S_START && run && prox_en;
   endsequence
   sequence s_conv_done;
      state_ff == S_CONVERT && i_adc_done && run;
   endsequence
   a_one_channel: assert property ((o_charge_en && o_mux_sel != `CTM_PROX_CH)
      |-> $countones(~o_short_gnd) == 1)
      else $error("more than one input released from ground");
   a_others_ground: assert property ((o_charge_en && o_mux_sel != `CTM_PROX_CH)
      |-> o_short_gnd == ~ctm_onehot(o_mux_sel))
      else $error("non-measured input not grounded");
   a_discharge_follows: assert property (s_conv_done |=> o_discharge && o_short_gnd == 13'h1FFF)
      else $error("channel not discharged after conversion");
   a_current_floor: assert property (o_charge_en |-> o_charge_current >= `CTM_CUR_MIN)
      else $error("charge current below minimum");
   a_charge_length: assert property (o_adc_start |-> chg_len_ff == chg_exp_ff)
      else $error("charge period length wrong");
   a_adc_after_charge: assert property (o_adc_start |-> $past(o_charge_en) && !o_charge_en)
      else $error("conversion not at end of charge");
   a_stop_quiet: assert property (!run |=> state_ff == S_STOP && !o_charge_en ##1 !o_charge_en)
      else $error("measurement running while stopped");
   a_prox_first: assert property (s_cycle_start |=> o_mux_sel == `CTM_PROX_CH && o_charge_en)
      else $error("proximity channel not measured first");
   a_irq_on_change: assert property ((o_touch_status != $past(o_touch_status)) |-> !o_irq_n)
      else $error("status change without interrupt");

endmodule : ctm_core
`default_nettype wire

//--- bench/ctm_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctm_adc_model (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_adc_start,
   input wire logic [5:0] i_charge_current,
   input wire logic [12:0][15:0] i_cap,
   input wire logic [3:0] i_mux_sel,
   input wire logic [3:0] i_lat,
   output logic o_adc_done,
   output ctm_pkg::ctm_sample_t o_adc_data
);
   import ctm_pkg::*;
   int cnt;
   logic odd;
   initial begin
      o_adc_done = 1'b0;
      o_adc_data = 10'h155;
      odd = 1'b0;
      forever begin
         @(posedge i_clk_sys);
         if (i_sys_rst) begin
            odd = 1'b0;
         end else if (i_adc_start === 1'b1) begin
            // Count rises with charge and falls with capacitance
            cnt = i_charge_current * 4096 / i_cap[i_mux_sel];
            // Alternating offset cancels only if an even number of samples is averaged
            cnt = odd ? cnt - 2 : cnt + 2;
            odd = ~odd;
            repeat (i_lat) @(posedge i_clk_sys);
            o_adc_done <= 1'b1;
            o_adc_data <= 10'(cnt);
            @(posedge i_clk_sys);
            o_adc_done <= 1'b0;
            o_adc_data <= ~10'(cnt);
         end
      end
   end
endmodule : ctm_adc_model
`default_nettype wire

//--- bench/ctm_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctm_core_regs.svh"
module ctm_core_tb;
   import ctm_pkg::*;
   typedef struct {logic [3:0] ch; logic [5:0] cur;} ctm_exp_t;
   logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_autocfg_start, i_irq_ack, i_adc_done;
   logic [7:0] i_electrode_config_reg;
   logic [5:0] i_charge_current;
   logic [2:0] i_charge_time, i_second_stage_sample_interval, i_base_shift_ele, i_base_shift_prox;
   logic [1:0] i_first_stage_sample_count, i_second_stage_sample_count;
   logic [2:0] i_debounce_touch, i_debounce_release;
   ctm_thr_t [12:0] i_touch_thr, i_release_thr;
   ctm_sample_t i_autocfg_target, i_adc_data;
   logic [3:0] o_mux_sel, lat = 4'h0;
   logic [12:0] o_short_gnd, o_touch_status, m;
   logic o_charge_en, o_adc_start, o_discharge, o_autocfg_busy, o_irq_n, pc = 1'b0;
   logic [5:0] o_charge_current;
   ctm_sample_t [12:0] o_filtered_data;
   ctm_base8_t [12:0] o_baseline;
   logic [12:0][15:0] i_cap;
   logic [31:0] rs = 32'h00000053;
   int n_errors = 0, samples_checked = 0, i, k, n;
   ctm_exp_t q[$], e;
   ctm_core #(.P_PERIOD_CYCLES(200)) uut (.i_clk_sys, .i_sys_rst, .i_electrode_config_reg, .i_charge_current,
      .i_charge_time, .i_first_stage_sample_count, .i_second_stage_sample_count, .i_second_stage_sample_interval,
      .i_base_shift_ele, .i_base_shift_prox, .i_touch_thr, .i_release_thr, .i_debounce_touch, .i_debounce_release,
      .i_autocfg_start, .i_autocfg_target, .i_irq_ack, .i_adc_done, .i_adc_data, .o_mux_sel, .o_short_gnd,
      .o_charge_en, .o_charge_current, .o_adc_start, .o_discharge, .o_autocfg_busy, .o_filtered_data,
      .o_baseline, .o_touch_status, .o_irq_n);
   ctm_adc_model adc (.i_clk_sys, .i_sys_rst, .i_adc_start(o_adc_start), .i_charge_current(o_charge_current),
      .i_cap, .i_mux_sel(o_mux_sel), .i_lat(lat), .o_adc_done(i_adc_done), .o_adc_data(i_adc_data));
   always #5 i_clk_sys = ~i_clk_sys;
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs
   function automatic logic [5:0] acfg(input int cap);
      int b;
      logic [5:0] c;
      c = 6'h00;
      for (b = 5; b >= 0; b--) begin
         c[b] = 1'b1;
         if (int'(c) * 4096 / cap > 800) c[b] = 1'b0;
      end
      return c;
   endfunction : acfg
   task end_sim();
      if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, g, x);
      end
   endtask : chk
   task hang(input int c, input int lim);
      if (c >= lim) begin
         n_errors++;
         $display("BAD %0t wait ran out", $time);
         end_sim();
      end
   endtask : hang
   task push(input logic [3:0] c, input logic [5:0] u);
      ctm_exp_t x;
      x.ch = c;
      x.cur = u;
      q.push_back(x);
      q.push_back(x);
   endtask : push
   task wait_done();
      for (k = 0; k < 9000 && q.size() > 0; k++) @(negedge i_clk_sys);
      hang(k, 9000);
      for (k = 0; k < 400 && o_discharge !== 1'b1; k++) @(negedge i_clk_sys);
      hang(k, 400);
      for (k = 0; k < 400 && o_discharge !== 1'b0; k++) @(negedge i_clk_sys);
      hang(k, 400);
      repeat (3) @(negedge i_clk_sys);
   endtask : wait_done
   task scan();
      push(4'hC, 6'h32);
      for (i = 0; i < 12; i++) push(4'(i), 6'h32);
      wait_done();
   endtask : scan
   task rst_chk();
      chk(o_short_gnd, 32'h1FFF);
      chk(o_charge_en, 0);
      chk(o_charge_current, 1);
      chk(o_irq_n, 1);
      chk(o_touch_status, 0);
      chk(o_autocfg_busy, 0);
   endtask : rst_chk
   always @(posedge i_clk_sys) if (o_adc_start === 1'b1) lat <= 4'(xs() % 8);
   // Each charge start takes the oldest expected channel note
   initial forever begin
      @(negedge i_clk_sys);
      while (o_charge_en === 1'b1 && pc === 1'b0 && q.size() > 0) begin
         e = q.pop_front();
         m = (e.ch == 4'hC) ? 13'h0000 : ~(13'h0001 << e.ch);
         chk(o_mux_sel, e.ch);
         chk(o_short_gnd, m);
         chk(o_charge_current, e.cur);
         n = 0;
         while (o_charge_en === 1'b1 && n < 200) begin
            n++;
            @(negedge i_clk_sys);
         end
         chk(n, 32'(`CTM_TCHG_UNIT_CYC) << (i_charge_time - 3'h1));
         chk(o_adc_start, 1);
         @(negedge i_clk_sys);
         chk(o_adc_start, 0);
         for (n = 0; n < 50 && o_discharge !== 1'b1; n++) @(negedge i_clk_sys);
         chk(o_short_gnd, 32'h1FFF);
         n = 0;
         while (o_discharge === 1'b1 && n < 300) begin
            n++;
            @(negedge i_clk_sys);
         end
         chk(n, 100);
         // Next sample may start charging on the edge that ends discharge
         pc = 1'b0;
      end
      pc = o_charge_en;
   end
   initial begin
      repeat (90000) @(posedge i_clk_sys);
      n_errors++;
      $display("BAD %0t run too long", $time);
      end_sim();
   end
   initial begin
      i_electrode_config_reg = 8'h00;
      i_charge_current = 6'h32;
      i_charge_time = 3'h1;
      i_first_stage_sample_count = 2'h1;
      i_second_stage_sample_count = 2'h0;
      i_second_stage_sample_interval = 3'h0;
      i_base_shift_ele = 3'h7;
      i_base_shift_prox = 3'h0;
      i_debounce_touch = 3'h2;
      i_debounce_release = 3'h1;
      i_autocfg_start = 1'b0;
      i_autocfg_target = 10'h320;
      i_irq_ack = 1'b0;
      for (i = 0; i < 13; i++) begin
         i_touch_thr[i] = 8'(xs() % 100 + 40);
         i_release_thr[i] = 8'h0A;
         i_cap[i] = 16'h0100;
      end
      i_touch_thr[3] = 8'h14;
      i_touch_thr[5] = 8'h28;
      repeat (4) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      @(negedge i_clk_sys);
      rst_chk();
      @(posedge i_clk_sys);
      i_electrode_config_reg <= 8'h3C;
      scan();
      for (i = 0; i < 13; i++) begin
         chk(o_filtered_data[i], 32'h320);
         chk(o_baseline[i], 32'hC8);
      end
      chk(o_touch_status, 0);
      @(posedge i_clk_sys);
      i_cap[3] <= 16'h010B;
      i_cap[5] <= 16'h010B;
      i_cap[12] <= 16'h010B;
      scan();
      chk(o_touch_status[3], 0);
      scan();
      chk(o_touch_status[3], 0);
      chk(o_baseline[12], 32'hBF);
      scan();
      chk(o_touch_status[3], 1);
      chk(o_touch_status[5], 0);
      chk(o_irq_n, 0);
      chk(o_baseline[3], 32'hC7);
      chk(o_filtered_data[3], 32'h2FF);
      @(posedge i_clk_sys);
      i_irq_ack <= 1'b1;
      i_cap[3] <= 16'h0100;
      i_cap[5] <= 16'h0100;
      @(posedge i_clk_sys);
      i_irq_ack <= 1'b0;
      @(negedge i_clk_sys);
      chk(o_irq_n, 1);
      scan();
      chk(o_touch_status[3], 1);
      scan();
      chk(o_touch_status[3], 0);
      chk(o_irq_n, 0);
      for (k = 0; k < 400 && o_charge_en !== 1'b1; k++) @(negedge i_clk_sys);
      hang(k, 400);
      @(posedge i_clk_sys);
      i_electrode_config_reg <= 8'h00;
      repeat (2) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      chk(o_charge_en, 0);
      chk(o_short_gnd, 32'h1FFF);
      repeat (300) @(negedge i_clk_sys);
      chk(o_charge_en, 0);
      @(posedge i_clk_sys);
      i_sys_rst <= 1'b1;
      i_cap[1] <= 16'h0140;
      i_charge_time <= 3'h2;
      repeat (4) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      @(negedge i_clk_sys);
      rst_chk();
      @(posedge i_clk_sys);
      i_electrode_config_reg <= 8'h02;
      i_autocfg_start <= 1'b1;
      @(posedge i_clk_sys);
      i_autocfg_start <= 1'b0;
      for (k = 0; k < 500 && o_autocfg_busy !== 1'b1; k++) @(negedge i_clk_sys);
      hang(k, 500);
      for (k = 0; k < 30000 && o_autocfg_busy !== 1'b0; k++) @(negedge i_clk_sys);
      hang(k, 30000);
      push(4'h0, acfg(256));
      push(4'h1, acfg(320));
      wait_done();
      end_sim();
   end
endmodule : ctm_core_tb
`default_nettype wire
